/* src/fbm_defs.svh */
// timing counts and pin layout for the flash bus-mode host controller
// assumes a 40 MHz system clock; included by the package and the top module
//
// Behaviour
// - read: chip select, output enable low
// - write: write enable, chip select low
// - fast program needs two writes, not four; fbm_host sends one bus write per request and leaves both writes to the user
// - host restarts operation interrupted by reset; fbm_host leaves this to the user, who re-sends it
// - no read data before reset-high recovery
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH

`define FBM_CLK_MHZ 40
`define FBM_ACCESS_NS 70
`define FBM_MIN_RESET_PULSE_NS 500
`define FBM_RESET_HIGH_TO_READ_NS 50
`define FBM_WRITE_PULSE_NS 35
`define FBM_SLEEP_EXTRA_NS 30
// least times round up to whole cycles
`define FBM_NS2CYC(ns) (((ns) * `FBM_CLK_MHZ + 999) / 1000)
`define FBM_ACCESS_CYC `FBM_NS2CYC(`FBM_ACCESS_NS)
`define FBM_RESET_PULSE_CYC `FBM_NS2CYC(`FBM_MIN_RESET_PULSE_NS)
`define FBM_RESET_HIGH_CYC `FBM_NS2CYC(`FBM_RESET_HIGH_TO_READ_NS)
`define FBM_WRITE_CYC `FBM_NS2CYC(`FBM_WRITE_PULSE_NS)
`define FBM_SLEEP_CYC `FBM_NS2CYC(`FBM_ACCESS_NS + `FBM_SLEEP_EXTRA_NS)
`define FBM_DATA_W 16
`define FBM_ADDR_W 20
`define FBM_TOP_PIN 15

`endif

/* src/fbm_pkg.sv */
// types shared by the flash bus-mode host controller
// assumes fbm_defs.svh is on the include path
`include "fbm_defs.svh"
package fbm_pkg;

	typedef enum logic [1:0] {
		FBM_OP_READ = 2'b00,
		FBM_OP_WRITE = 2'b01,
		FBM_OP_RESET = 2'b10
	} fbm_op_type;

	// one request from the user side
	typedef struct packed {
		fbm_op_type op;
		logic byte_mode;
		logic [`FBM_ADDR_W-1:0] addr;
		logic byte_lsb;
		logic [`FBM_DATA_W-1:0] wdata;
	} fbm_req_type;

	// control pins toward the flash, all active low except width select
	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic wr_en_n;
		logic reset_n;
		logic word_sel;
	} fbm_ctl_type;

endpackage

/* src/fbm_tick_counter.sv */
// down counter that times one bus phase
// assumes load and count are from the same clock domain
`timescale 1ns/10ps
module fbm_tick_counter #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] value,
	// status
	output logic done
);
	logic [WIDTH-1:0] cnt_r;

	// refuse widths the down counter cannot serve
	if (WIDTH < 2) begin : g_width_check
		$error("fbm_tick_counter: WIDTH too small");
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= '0;
		else if (load)
			cnt_r <= value;
		else if (cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	// done looks at the count only, so a reload on done forms no loop
	assign done = (cnt_r == '0);
endmodule

/* src/fbm_host.sv */
// host controller that drives a parallel boot-sector flash over its pins
// assumes pin inputs already synchronous to clk; one request at a time
`timescale 1ns/10ps
`include "fbm_defs.svh"
module fbm_host (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// user request
	input wire logic req_valid,
	input wire fbm_pkg::fbm_req_type req,
	output logic req_ready,
	// user answer
	output logic rsp_valid,
	output logic [`FBM_DATA_W-1:0] rsp_data,
	output logic flash_busy,
	// flash control pins
	output fbm_pkg::fbm_ctl_type ctl,
	output logic [`FBM_ADDR_W-1:0] addr,
	// flash data pins, three signals each
	input wire logic [`FBM_DATA_W-1:0] data_pins_i,
	output logic [`FBM_DATA_W-1:0] data_pins_o,
	output logic [`FBM_DATA_W-1:0] data_pins_oe,
	// flash done indicator, low while busy
	input wire logic done_indicator_n
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_WRITE = 3'b010,
		ST_WREC = 3'b011,
		ST_RST = 3'b100,
		ST_RREC = 3'b101
	} st_type;

	// ======================================================
	// phase timer
	// ======================================================
	st_type st_r;
	logic tmr_load;
	logic [7:0] tmr_val;
	logic tmr_done;
	logic go;

	fbm_tick_counter #(.WIDTH(8)) u_tmr (
		.clk(clk),
		.rst_n(rst_n),
		.load(tmr_load),
		.value(tmr_val),
		.done(tmr_done)
	);

	assign go = req_valid && req_ready;

	always_comb begin
		tmr_load = 1'b0;
		tmr_val = 8'h00;
		if (go) begin
			tmr_load = 1'b1;
			case (req.op)
				fbm_pkg::FBM_OP_WRITE:
					tmr_val = 8'(`FBM_WRITE_CYC);
				fbm_pkg::FBM_OP_RESET:
					tmr_val = 8'(`FBM_RESET_PULSE_CYC);
				default:
					tmr_val = 8'(`FBM_ACCESS_CYC);
			endcase
		end else if (st_r == ST_WRITE && tmr_done) begin
			tmr_load = 1'b1;
			tmr_val = 8'h01;
		end else if (st_r == ST_RST && tmr_done) begin
			tmr_load = 1'b1;
			tmr_val = 8'(`FBM_RESET_HIGH_CYC);
		end
	end

	// ======================================================
	// sequencer
	// ======================================================
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_r <= ST_IDLE;
		else begin
			case (st_r)
				ST_IDLE:
					if (go) begin
						case (req.op)
							fbm_pkg::FBM_OP_WRITE: st_r <= ST_WRITE;
							fbm_pkg::FBM_OP_RESET: st_r <= ST_RST;
							default: st_r <= ST_READ;
						endcase
					end
				ST_READ:
					if (tmr_done)
						st_r <= ST_IDLE;
				ST_WRITE:
					if (tmr_done)
						st_r <= ST_WREC;
				ST_WREC:
					if (tmr_done)
						st_r <= ST_IDLE;
				ST_RST:
					if (tmr_done)
						st_r <= ST_RREC;
				ST_RREC:
					if (tmr_done)
						st_r <= ST_IDLE;
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			req_ready <= 1'b0;
		else
			req_ready <= (st_r == ST_IDLE) && !go && !req_ready ||
				(st_r == ST_IDLE && req_ready && !go) ||
				(tmr_done && (st_r == ST_READ || st_r == ST_WREC ||
				st_r == ST_RREC));
	end

	// ======================================================
	// pins
	// ======================================================
	logic bm_r;
	logic [`FBM_DATA_W-1:0] wd_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// reset_n idles high: reads need no command first
			ctl <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
				reset_n: 1'b1, word_sel: 1'b1};
			addr <= '0;
			bm_r <= 1'b0;
			wd_r <= '0;
		end else if (go) begin
			bm_r <= req.byte_mode;
			ctl.word_sel <= !req.byte_mode;
			addr <= req.addr;
			wd_r <= req.wdata;
			// read keeps write enable high, write keeps oe high
			ctl.chip_sel_n <= (req.op == fbm_pkg::FBM_OP_RESET);
			ctl.out_en_n <= (req.op != fbm_pkg::FBM_OP_READ);
			// one bus write per request, so short sequences cost fewer requests
			ctl.wr_en_n <= (req.op != fbm_pkg::FBM_OP_WRITE);
			ctl.reset_n <= (req.op != fbm_pkg::FBM_OP_RESET);
		end else if (tmr_done) begin
			// end of phase: deselect, device idles into standby
			ctl.chip_sel_n <= 1'b1;
			ctl.out_en_n <= 1'b1;
			ctl.wr_en_n <= 1'b1;
			ctl.reset_n <= 1'b1;
		end
	end

	// top pin carries the byte lsb in byte mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_pins_o <= '0;
			data_pins_oe <= '0;
		end else if (go) begin
			data_pins_o <= req.wdata;
			data_pins_oe <= '0;
			if (req.op == fbm_pkg::FBM_OP_WRITE)
				data_pins_oe <= req.byte_mode ? 16'h80ff : 16'hffff;
			else if (req.byte_mode && req.op == fbm_pkg::FBM_OP_READ)
				data_pins_oe <= 16'h8000;
			if (req.byte_mode)
				data_pins_o[`FBM_TOP_PIN] <= req.byte_lsb;
		end else if (tmr_done && st_r != ST_WRITE) begin
			data_pins_oe <= '0;
		end
	end

	// ======================================================
	// answer
	// ======================================================
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_data <= '0;
		end else begin
			rsp_valid <= (st_r == ST_READ) && tmr_done;
			if (st_r == ST_READ && tmr_done)
				// id and status sit on the low byte
				rsp_data <= bm_r ? {8'h00, data_pins_i[7:0]} : data_pins_i;
		end
	end

	// busy while device says so or reset runs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			flash_busy <= 1'b1;
		else
			flash_busy <= !done_indicator_n || st_r == ST_RST ||
				st_r == ST_RREC;
	end

	// ======================================================
	// checks
	// ======================================================
	AST_RD_WE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
		!ctl.out_en_n |-> ctl.wr_en_n) else $error("oe and we both low");
	AST_WR_OE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
		!ctl.wr_en_n |-> ctl.out_en_n && !ctl.chip_sel_n)
		else $error("write without cs or with oe");
	AST_RST_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(ctl.reset_n) |-> !ctl.reset_n [*8])
		else $error("reset pulse too short");
	AST_RST_REC: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ctl.reset_n) |-> ctl.out_en_n [*2])
		else $error("read too soon after reset");
	AST_NO_DRIVE_ON_READ: assert property (@(posedge clk)
		disable iff (!rst_n)
		!ctl.out_en_n |-> data_pins_oe[14:0] == 15'h0000)
		else $error("host drives data during read");
	AST_BYTE_PINS: assert property (@(posedge clk) disable iff (!rst_n)
		(!ctl.wr_en_n && !ctl.word_sel) |-> data_pins_oe[14:8] == 7'h00)
		else $error("high byte driven in byte mode");
	AST_READ_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(ctl.out_en_n) |-> !ctl.out_en_n [*3])
		else $error("read shorter than access time");
	AST_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
		!done_indicator_n |=> flash_busy)
		else $error("busy not reported");
endmodule

/* tb/fbm_flash_model.sv */
// behavioural flash device facing the host controller
// assumes the bench resolves the data wire and feeds it back as dq_i
`timescale 1ns/10ps
module fbm_flash_model #(
	parameter logic [7:0] STATUS = 8'h4c,
	parameter int BUSY_NS = 2000,
	parameter int READY_NS = 300
) (
	// control and address
	input wire fbm_pkg::fbm_ctl_type ctl,
	input wire logic [19:0] addr,
	// data wire
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic [15:0] dq_oe,
	// busy
	input wire logic start,
	output logic done_indicator_n
);
	// ====
	// array, reads and writes
	logic [7:0] mem [0:511];
	logic running = 1'b0;
	logic [8:0] bi;
	logic rd;
	initial foreach (mem[i]) mem[i] = 8'hff;
	assign bi = {addr[7:0], dq_i[15]};
	assign rd = ctl.reset_n & ~ctl.chip_sel_n & ~ctl.out_en_n;
	assign dq_oe = !rd ? 16'h0000 : ctl.word_sel ? 16'hffff : 16'h00ff;
	assign dq_o = running ? {8'h00, STATUS} : ctl.word_sel ?
		{mem[{addr[7:0], 1'b1}], mem[{addr[7:0], 1'b0}]} : {8'h00, mem[bi]};
	// cell is taken once per write strobe, after the pins have settled
	always @(negedge ctl.wr_en_n) begin
		#5;
		if (ctl.reset_n && !ctl.chip_sel_n && !ctl.wr_en_n && !running) begin
			if (ctl.word_sel) begin
				mem[{addr[7:0], 1'b0}] = dq_i[7:0];
				mem[{addr[7:0], 1'b1}] = dq_i[15:8];
			end else begin
				mem[bi] = dq_i[7:0];
			end
		end
	end
	// ====
	// embedded operation and hardware reset
	assign done_indicator_n = ~running;
	always @(posedge start) begin
		running = 1'b1;
		#(BUSY_NS) running = 1'b0;
	end
	always @(negedge ctl.reset_n) if (running) #(READY_NS) running = 1'b0;
endmodule

/* tb/fbm_host_tb.sv */
// self-checking bench for the flash bus-mode host controller
// assumes fbm_flash_model at the far side and a 40 MHz clock
`timescale 1ns/10ps
module fbm_host_tb;
	// ====
	// clock, reset and wires
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	fbm_pkg::fbm_req_type req = '0;
	logic start = 1'b0;
	logic req_ready, rsp_valid, flash_busy, done_n;
	logic [15:0] rsp_data, dq, h_o, h_oe, m_o, m_oe;
	logic [15:0] flt = 16'h5a5a;
	logic [19:0] addr;
	fbm_pkg::fbm_ctl_type ctl;
	int bad_count = 0;
	int checks = 0;
	int rlow = 0;
	int rhigh = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) flt <= ~flt;
	// released lines show a changing pattern, not the last value
	assign dq = (h_oe & h_o) | (~h_oe & m_oe & m_o) | (~h_oe & ~m_oe & flt);
	fbm_host u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .flash_busy(flash_busy), .ctl(ctl),
		.addr(addr), .data_pins_i(dq), .data_pins_o(h_o),
		.data_pins_oe(h_oe), .done_indicator_n(done_n));
	fbm_flash_model u_flash (.ctl(ctl), .addr(addr), .dq_i(dq),
		.dq_o(m_o), .dq_oe(m_oe), .start(start), .done_indicator_n(done_n));
	// ====
	// shared tasks
	task automatic check(input string name, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic send(input fbm_pkg::fbm_op_type op, input logic bm,
		input logic [19:0] a, input logic lsb, input logic [15:0] wd);
		int n = 0;
		while (req_ready !== 1'b1) begin
			@(posedge clk);
			#2;
			n++;
			if (n > 100) begin
				bad_count++;
				complete_run;
			end
		end
		req_valid = 1'b1;
		req = '{op, bm, a, lsb, wd};
		@(posedge clk);
		#2;
		req_valid = 1'b0;
	endtask
	task automatic rd(input logic bm, input logic [19:0] a, input logic lsb,
		input logic [15:0] exp, input string name);
		int n = 0;
		send(fbm_pkg::FBM_OP_READ, bm, a, lsb, 16'h0000);
		while (rsp_valid !== 1'b1 && n < 10) begin
			@(posedge clk);
			#2;
			n++;
		end
		check("rsp_valid", rsp_valid, 1'b1);
		check(name, rsp_data, exp);
	endtask
	task automatic wr(input logic bm, input logic [19:0] a, input logic lsb,
		input logic [15:0] wd, input logic [15:0] oe);
		send(fbm_pkg::FBM_OP_WRITE, bm, a, lsb, wd);
		check("word_sel", ctl.word_sel, !bm);
		check("addr", addr[15:0], a[15:0]);
		check("drive_en", h_oe, oe);
		check("drive_val", h_o & oe, bm ? {lsb, 7'h00, wd[7:0]} : wd);
	endtask
	// ====
	// pin-level watch on every cycle
	always @(negedge clk) begin
		if (rst_n) begin
			if (!ctl.reset_n) rlow++;
			rhigh = ctl.reset_n ? rhigh + 1 : 0;
			if (!ctl.chip_sel_n && !ctl.wr_en_n)
				check("oe_in_write", ctl.out_en_n, 1'b1);
			if (!ctl.chip_sel_n && !ctl.out_en_n) begin
				check("we_in_read", ctl.wr_en_n, 1'b1);
				check("read_recovery", rhigh >= 2, 1'b1);
				check("host_off", h_oe & 16'h7fff, 16'h0000);
			end
		end
	end
	// ====
	// scenarios
	task automatic traffic;
		rd(1'b0, 20'h00007, 1'b0, 16'hffff, "erased");
		wr(1'b0, 20'h00011, 1'b0, 16'hbeef, 16'hffff);
		wr(1'b1, 20'h00022, 1'b1, 16'h00a5, 16'h80ff);
		rd(1'b0, 20'h00011, 1'b0, 16'hbeef, "word");
		rd(1'b1, 20'h00011, 1'b1, 16'h00be, "byte_hi");
		rd(1'b1, 20'h00022, 1'b1, 16'h00a5, "byte");
		rd(1'b0, 20'h00022, 1'b0, 16'ha5ff, "word_of_byte");
	endtask
	task automatic busy_reset;
		start = 1'b1;
		repeat (3) @(posedge clk);
		#2;
		check("busy", flash_busy, 1'b1);
		rd(1'b0, 20'h00011, 1'b0, 16'h004c, "status");
		rlow = 0;
		send(fbm_pkg::FBM_OP_RESET, 1'b0, 20'h00000, 1'b0, 16'h0000);
		rd(1'b0, 20'h00011, 1'b0, 16'hbeef, "after_reset");
		check("reset_width", rlow >= 20, 1'b1);
		check("idle", flash_busy, 1'b0);
		wr(1'b0, 20'h00011, 1'b0, 16'hbeef, 16'hffff);
		rd(1'b0, 20'h00011, 1'b0, 16'hbeef, "restarted");
		start = 1'b0;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#2;
		check("rst_ctl", ctl, 16'h001f);
		check("rst_busy", flash_busy, 1'b1);
		rst_n = 1'b1;
		traffic;
		busy_reset;
		complete_run;
	end
endmodule
